// ### common/port_power_pkg.sv
// constants for the downstream port power control block
package port_power_pkg;
  // =====================================
  // port counts
  localparam int unsigned num_ports = 4;
  localparam int unsigned num_typec_ports = 2;
  // =====================================
  // overcurrent filter
  localparam int unsigned filter_cycles = 4;
  localparam int unsigned filter_width = 3;
  localparam logic [filter_width-1:0] filter_zero = 3'h0;
  localparam logic [filter_width-1:0] filter_one = 3'h1;
  localparam logic [filter_width-1:0] filter_full = 3'h4;
  // =====================================
  // per port sense state
  typedef enum logic [1:0] {
    sense_off = 2'b00,
    sense_watch = 2'b01,
    sense_fault = 2'b10
  } sense_state_t;
endpackage

// ### src/port_sense_channel.sv
// one port: pin direction, sense synchroniser, overcurrent filter
`timescale 1ns/100ps
module port_sense_channel
  import port_power_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic port_en,
  input wire logic fault_clear,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup_en,
  // status
  output logic overcurrent,
  output logic overcurrent_event
);
  import port_power_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [filter_width-1:0] cnt_q;
  sense_state_t state_q;
  logic event_q;

  // =====================================
  // pin drive
  assign pin_out = 1'b0;
  assign pin_oe = ~port_en;
  assign pin_pullup_en = port_en;

  // =====================================
  // synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // =====================================
  // low level filter
  always_ff @(posedge clk) begin
    if (sys_rst || !port_en || sync2_q) begin
      cnt_q <= filter_zero;
    end else if (cnt_q != filter_full) begin
      cnt_q <= cnt_q + filter_one;
    end
  end

  // =====================================
  // sense state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= sense_off;
      event_q <= 1'b0;
    end else begin
      event_q <= 1'b0;
      case (state_q)
        sense_off: begin
          if (port_en) begin
            state_q <= sense_watch;
          end
        end
        sense_watch: begin
          if (!port_en) begin
            state_q <= sense_off;
          end else if (cnt_q == filter_full) begin
            state_q <= sense_fault;
            event_q <= 1'b1;
          end
        end
        sense_fault: begin
          if (fault_clear && cnt_q != filter_full) begin
            state_q <= port_en ? sense_watch : sense_off;
          end
        end
        default: begin
          state_q <= sense_off;
        end
      endcase
    end
  end

  assign overcurrent = (state_q == sense_fault);
  assign overcurrent_event = event_q;
endmodule

// ### src/downstream_port_power_control.sv
// downstream port power enable and overcurrent sense for four hub ports
// Contract
// - one combined power-enable and overcurrent-sense pin per downstream port 1 to 4
// - enabled port: pin is an input with pull-up, driver released
// - low pin on an enabled port means overcurrent
// - disabled port: pin becomes an output driven low
// - one pin governs both high-speed and superspeed parts of a port
// - ports 1 and 2 get two connector-supply enables, one per orientation
// - ports 1 and 2 get a bus discharge enable output
`timescale 1ns/100ps
module downstream_port_power_control
  import port_power_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // port control from hub logic
  input wire logic [port_power_pkg::num_ports-1:0] port_en,
  input wire logic [port_power_pkg::num_ports-1:0] fault_clear,
  // type-c supply controls from hub logic
  input wire logic [port_power_pkg::num_typec_ports-1:0] conn_supply_req_a,
  input wire logic [port_power_pkg::num_typec_ports-1:0] conn_supply_req_b,
  input wire logic [port_power_pkg::num_typec_ports-1:0] bus_drain_req,
  // port power pins
  input wire logic port1_power_sense_in,
  output logic port1_power_sense_out,
  output logic port1_power_sense_oe,
  output logic port1_power_sense_pu,
  input wire logic port2_power_sense_in,
  output logic port2_power_sense_out,
  output logic port2_power_sense_oe,
  output logic port2_power_sense_pu,
  input wire logic port3_power_sense_in,
  output logic port3_power_sense_out,
  output logic port3_power_sense_oe,
  output logic port3_power_sense_pu,
  input wire logic port4_power_sense_in,
  output logic port4_power_sense_out,
  output logic port4_power_sense_oe,
  output logic port4_power_sense_pu,
  // connector supply and discharge pins
  output logic port1_conn_supply_en_a,
  output logic port1_conn_supply_en_b,
  output logic port2_conn_supply_en_a,
  output logic port2_conn_supply_en_b,
  output logic port1_bus_drain_en,
  output logic port2_bus_drain_en,
  // status, common to both speed portions of each port
  output logic [port_power_pkg::num_ports-1:0] overcurrent,
  output logic [port_power_pkg::num_ports-1:0] overcurrent_event
);
  import port_power_pkg::*;

  logic [num_ports-1:0] pin_in;
  logic [num_ports-1:0] pin_out;
  logic [num_ports-1:0] pin_oe;
  logic [num_ports-1:0] pin_pu;
  logic [num_typec_ports-1:0] supply_a_q;
  logic [num_typec_ports-1:0] supply_b_q;
  logic [num_typec_ports-1:0] drain_q;

  // =====================================
  // pin gathering
  assign pin_in = {port4_power_sense_in, port3_power_sense_in,
                   port2_power_sense_in, port1_power_sense_in};
  assign port1_power_sense_out = pin_out[0];
  assign port2_power_sense_out = pin_out[1];
  assign port3_power_sense_out = pin_out[2];
  assign port4_power_sense_out = pin_out[3];
  assign port1_power_sense_oe = pin_oe[0];
  assign port2_power_sense_oe = pin_oe[1];
  assign port3_power_sense_oe = pin_oe[2];
  assign port4_power_sense_oe = pin_oe[3];
  assign port1_power_sense_pu = pin_pu[0];
  assign port2_power_sense_pu = pin_pu[1];
  assign port3_power_sense_pu = pin_pu[2];
  assign port4_power_sense_pu = pin_pu[3];

  // =====================================
  // one channel per port, shared by both speed portions
  genvar g;
  generate
    for (g = 0; g < num_ports; g++) begin : g_port
      port_sense_channel u_chan (
        .clk(clk),
        .sys_rst(sys_rst),
        .port_en(port_en[g]),
        .fault_clear(fault_clear[g]),
        .pin_in(pin_in[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .pin_pullup_en(pin_pu[g]),
        .overcurrent(overcurrent[g]),
        .overcurrent_event(overcurrent_event[g])
      );
    end
  endgenerate

  // =====================================
  // connector supply enables, off while the port is down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_a_q <= '0;
      supply_b_q <= '0;
    end else begin
      supply_a_q <= conn_supply_req_a & port_en[num_typec_ports-1:0];
      supply_b_q <= conn_supply_req_b & port_en[num_typec_ports-1:0];
    end
  end

  // =====================================
  // bus discharge enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drain_q <= '0;
    end else begin
      drain_q <= bus_drain_req;
    end
  end

  assign port1_conn_supply_en_a = supply_a_q[0];
  assign port1_conn_supply_en_b = supply_b_q[0];
  assign port2_conn_supply_en_a = supply_a_q[1];
  assign port2_conn_supply_en_b = supply_b_q[1];
  assign port1_bus_drain_en = drain_q[0];
  assign port2_bus_drain_en = drain_q[1];
endmodule

// ### verification/port_power_sva.sv
// checker for port 1 pin direction and overcurrent status
`timescale 1ns/100ps
module port_power_sva
  import port_power_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched ports
  input wire logic [num_ports-1:0] port_en,
  input wire logic [num_ports-1:0] fault_clear,
  input wire logic port1_power_sense_in,
  input wire logic port1_power_sense_out,
  input wire logic port1_power_sense_oe,
  input wire logic port1_power_sense_pu,
  input wire logic [num_ports-1:0] overcurrent,
  input wire logic [num_ports-1:0] overcurrent_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // pin and fault
  pin_input_a: assert property (port_en[0] |-> port1_power_sense_pu && !port1_power_sense_oe)
    else $error("pin not input");
  pin_drive_a: assert property (!port_en[0] |-> port1_power_sense_oe && !port1_power_sense_out)
    else $error("pin not low");
  fault_delay_a: assert property ((port_en[0] && !port1_power_sense_in) [*7] |=> overcurrent[0])
    else $error("fault late");
  fault_cause_a: assert property ($rose(overcurrent[0]) |-> !$past(port1_power_sense_in, 5))
    else $error("fault no cause");
  event_rise_a: assert property ($rose(overcurrent[0]) |-> overcurrent_event[0])
    else $error("no event");
  event_pulse_a: assert property (overcurrent_event[0] |=> !overcurrent_event[0])
    else $error("event long");
  fault_hold_a: assert property (overcurrent[0] && !fault_clear[0] |=> overcurrent[0])
    else $error("fault lost");
  fault_clear_a: assert property (port1_power_sense_in [*5] ##0 (overcurrent[0] && fault_clear[0]) |=> !overcurrent[0])
    else $error("clear ignored");
  cover property (overcurrent_event[0]);
  cover property (overcurrent[0] && fault_clear[0]);
  cover property (port_en[0] && !port1_power_sense_in);
endmodule
bind downstream_port_power_control port_power_sva i_port_power_sva (.clk, .sys_rst, .port_en, .fault_clear,
  .port1_power_sense_in, .port1_power_sense_out, .port1_power_sense_oe, .port1_power_sense_pu, .overcurrent,
  .overcurrent_event);

// ### verification/port_switch_model.sv
// far side of the port pins: power switch and current monitor
`timescale 1ns/100ps
module port_switch_model (
  // hub side of each pin
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  input wire logic [3:0] pu,
  // monitor command and wire level, high powers the port
  input wire logic [3:0] fault,
  output logic [3:0] pin
);
  assign pin = (oe & out) | (~oe & ~fault & pu);
endmodule

// ### verification/tb_downstream_port_power_control.sv
// self-checking bench for downstream port power control
`timescale 1ns/100ps
module tb_downstream_port_power_control;
  import port_power_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic [3:0] port_en = 0, fault_clear = 0, fault = 0, oe, out, pu, pin, oc, ev;
  logic [1:0] ra = 0, rb = 0, rd = 0;
  logic [5:0] cs;
  int miscompares = 0;
  int checks = 0;
  port_switch_model i_port_switch_model (.oe, .out, .pu, .fault, .pin);
  downstream_port_power_control i_downstream_port_power_control (.clk, .sys_rst, .port_en, .fault_clear,
    .conn_supply_req_a(ra), .conn_supply_req_b(rb), .bus_drain_req(rd), .overcurrent(oc), .overcurrent_event(ev),
    .port1_power_sense_in(pin[0]), .port1_power_sense_out(out[0]), .port1_power_sense_oe(oe[0]),
    .port1_power_sense_pu(pu[0]), .port2_power_sense_in(pin[1]), .port2_power_sense_out(out[1]),
    .port2_power_sense_oe(oe[1]), .port2_power_sense_pu(pu[1]), .port3_power_sense_in(pin[2]),
    .port3_power_sense_out(out[2]), .port3_power_sense_oe(oe[2]), .port3_power_sense_pu(pu[2]),
    .port4_power_sense_in(pin[3]), .port4_power_sense_out(out[3]), .port4_power_sense_oe(oe[3]),
    .port4_power_sense_pu(pu[3]), .port1_conn_supply_en_a(cs[0]), .port1_conn_supply_en_b(cs[1]),
    .port2_conn_supply_en_a(cs[2]), .port2_conn_supply_en_b(cs[3]), .port1_bus_drain_en(cs[4]),
    .port2_bus_drain_en(cs[5]));
  initial forever #4 clk = ~clk;
  initial begin
    #40000;
    miscompares++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========
  // scenarios
  task automatic t_pins();
    for (int m = 0; m < 16; m++) begin
      port_en = m[3:0];
      cyc(1);
      chk({oe, pu, pin, out}, {~m[3:0], m[3:0], m[3:0], 4'h0});
    end
  endtask
  task automatic t_supply();
    for (int m = 0; m < 256; m++) begin
      {port_en[1:0], rd, rb, ra} = m[7:0];
      cyc(1);
      chk({10'h0, cs}, {10'h0, rd, rb[1] & m[7], ra[1] & m[7], rb[0] & m[6], ra[0] & m[6]});
    end
  endtask
  task automatic t_fault(input int i);
    port_en = 4'hf;
    fault[i] = 1;
    cyc(6);
    chk({oc, ev}, 16'h0);
    cyc(1);
    chk({oc, ev}, {8'h0, {2{4'h1 << i}}});
    fault_clear[i] = 1;
    cyc(1);
    chk({oc, ev}, {8'h0, 4'h1 << i, 4'h0});
    fault_clear[i] = 0;
    port_en[i] = 0;
    fault[i] = 0;
    cyc(1);
    chk({oc, ev}, {8'h0, 4'h1 << i, 4'h0});
    if (i % 2 == 1) begin
      fault_clear[i] = 1;
      cyc(1);
      fault_clear[i] = 0;
      chk({oc, ev}, 16'h0);
    end
    port_en[i] = 1;
    cyc(4);
    fault_clear[i] = 1;
    cyc(1);
    fault_clear[i] = 0;
    chk({oc, ev}, 16'h0);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    t_pins();
    t_supply();
    for (int i = 0; i < 4; i++) t_fault(i);
    finish_test();
  end
endmodule
